//--- hdl/count_pulse_gen.sv
/*
  Count-pulse source for the timer: a free-running divider for the slow
  system-clock tick and a two-stage synchroniser with edge detector for the
  external event input.
  Assumes the event input is synchronous to clk by the time it arrives
  here or is at least slow against it; it is resynchronised anyway.
*/
`timescale 1ns/10ps
module count_pulse_gen
  import timer_event_pkg::*;
#(
  parameter int DIV = PRESCALE_DIV
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous, active high
  input wire logic [1:0] clock_select, // Count clock source
  input wire logic event_input_pin, // External event input
  output logic count_tick // One-cycle count enable
);

  localparam int DIV_W = $clog2(DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  logic [DIV_W-1:0] div_reg;
  logic div_tick;
  logic sync1_reg;
  logic sync2_reg;
  logic sync_prev_reg;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Free-running, so start of counting is not aligned to the tick
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= DIV_ZERO;
    end else begin
      div_reg <= (div_reg == DIV_LAST) ? DIV_ZERO : div_reg + DIV_W'(1);
    end
  end

  assign div_tick = (div_reg == DIV_LAST);

  // ----------------------------------------------------------------
  // Event input synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= event_input_pin;
      sync2_reg <= sync1_reg;
      sync_prev_reg <= sync2_reg;
    end
  end

  always_comb begin
    case (count_clock_e'(clock_select))
      CLK_SYSTEM: count_tick = 1'b1;
      CLK_DIV32: count_tick = div_tick;
      CLK_EDGE_RISE: count_tick = sync2_reg & ~sync_prev_reg;
      CLK_EDGE_FALL: count_tick = ~sync2_reg & sync_prev_reg;
      default: count_tick = 1'b0;
    endcase
  end

endmodule : count_pulse_gen

//--- hdl/timer_event_counter.sv
/*
  8-bit timer/event counter with its shared port pin: mode control,
  compare value, counter, square-wave output and the pin direction/latch.
  Assumes a single-cycle 8-bit register port (write strobe, read strobe,
  address) on the system clock; reads return data on the next cycle.
*/
// Notes on behaviour
// - Direction register resets to all ones
// - Match clears counter, keeps counting, raises interrupt
// - Match period is compare plus one
// - Event mode counts selected external edges
// - Square wave toggles pin on each match
// - Disabling counter forces square output low
// - Timer output starts low when enabled
// - First period may err one count clock
// - Enable low holds counter at zero
// - Two-bit field selects count clock source
// - External clock source disables timer output
// - Counter resets to zero, always readable
`timescale 1ns/10ps
module timer_event_counter
  import timer_event_pkg::*;
#(
  parameter int DIV = PRESCALE_DIV
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [DATA_W-1:0] reg_wdata, // Write data
  output logic [DATA_W-1:0] reg_rdata, // Read data, valid cycle after strobe
  input wire logic shared_port_pin_in, // Level seen on the shared pin
  output logic shared_port_pin_out, // Driven level of the shared pin
  output logic shared_port_pin_oe, // High while the pin is driven
  output logic match_irq // One-cycle match interrupt request
);

  logic [DATA_W-1:0] port5_direction_reg;
  logic [DATA_W-1:0] port5_latch_reg;
  logic [DATA_W-1:0] timer_mode_control_reg;
  logic [DATA_W-1:0] compare_value_reg;
  logic [DATA_W-1:0] count_value_reg;
  logic [DATA_W-1:0] count_value_next;
  logic timer_output_pin_reg;
  logic count_tick;
  logic count_enable;
  logic output_enable;
  logic external_clock;
  logic match;
  logic wr_mode;
  logic [DATA_W-1:0] rdata_next;
  logic wr_direction;
  logic wr_latch;
  logic wr_compare;
  logic square_drive;
  logic latch_level;

  // ----------------------------------------------------------------
  // Field and write decode
  // ----------------------------------------------------------------
  // Addresses are decoded in full, so unmapped writes fall away here
  assign count_enable = timer_mode_control_reg[COUNT_ENABLE_BIT];
  assign output_enable = timer_mode_control_reg[OUTPUT_ENABLE_BIT];
  assign external_clock = timer_mode_control_reg[CLOCK_SELECT_HI];
  assign wr_mode = reg_wr && (reg_addr == ADDR_TIMER_MODE_CONTROL);
  assign wr_direction = reg_wr && (reg_addr == ADDR_PORT5_DIRECTION);
  assign wr_latch = reg_wr && (reg_addr == ADDR_PORT5_LATCH);
  assign wr_compare = reg_wr && (reg_addr == ADDR_COMPARE_VALUE);

  // ----------------------------------------------------------------
  // Count pulse source
  // ----------------------------------------------------------------
  count_pulse_gen #(
    .DIV(DIV)
  ) u_pulse (
    .clk(clk),
    .reset(reset),
    .clock_select(timer_mode_control_reg[CLOCK_SELECT_HI:CLOCK_SELECT_LO]),
    .event_input_pin(shared_port_pin_in),
    .count_tick(count_tick)
  );

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      port5_direction_reg <= PORT5_DIRECTION_RESET;
    end else if (wr_direction) begin
      // Upper bits have no pin behind them and always stay one
      port5_direction_reg <= reg_wdata | PORT5_DIR_FIXED;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      port5_latch_reg <= PORT5_LATCH_RESET;
    end else if (wr_latch) begin
      port5_latch_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_mode_control_reg <= TIMER_MODE_RESET;
    end else if (wr_mode) begin
      timer_mode_control_reg <= reg_wdata & TIMER_MODE_MASK;
    end
  end

  // Any value 00..FF is accepted; a rewrite while running may match at once
  always_ff @(posedge clk) begin
    if (reset) begin
      compare_value_reg <= COMPARE_RESET;
    end else if (wr_compare) begin
      compare_value_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Counter and match
  // ----------------------------------------------------------------
  // Match is taken on the count pulse that would step past compare, so
  // counts 0..N give N+1 count-clock periods per interval.
  assign match = count_enable && count_tick && (count_value_reg == compare_value_reg);

  always_comb begin
    count_value_next = count_value_reg;
    if (!count_enable) begin
      count_value_next = COUNT_RESET;
    end else if (match) begin
      count_value_next = COUNT_RESET;
    end else if (count_tick) begin
      count_value_next = count_value_reg + COUNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_value_reg <= COUNT_RESET;
    end else begin
      count_value_reg <= count_value_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      match_irq <= 1'b0;
    end else begin
      // Registered so each request is one clean cycle; compare 00 on the system clock holds it high every cycle
      match_irq <= match;
    end
  end

  // ----------------------------------------------------------------
  // Square-wave output
  // ----------------------------------------------------------------
  // Turning the output on while running restarts the wave from low
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_output_pin_reg <= 1'b0;
    end else if (!count_enable) begin
      timer_output_pin_reg <= 1'b0;
    end else if (wr_mode && reg_wdata[OUTPUT_ENABLE_BIT] && !output_enable) begin
      timer_output_pin_reg <= 1'b0;
    end else if (match && output_enable) begin
      timer_output_pin_reg <= ~timer_output_pin_reg;
    end
  end

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------
  // Timer output only drives when the clock is internal; with an
  // external source the pin is the event input and the latch is used.
  // The pin follows the toggle one cycle late, so a stop reaches the
  // pin two cycles after the write that clears the enable.
  assign square_drive = output_enable && !external_clock;
  assign latch_level = port5_latch_reg[SHARED_PIN_DIR_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      shared_port_pin_oe <= 1'b0;
      shared_port_pin_out <= 1'b0;
    end else begin
      shared_port_pin_oe <= ~port5_direction_reg[SHARED_PIN_DIR_BIT];
      if (square_drive) begin
        shared_port_pin_out <= timer_output_pin_reg | latch_level;
      end else begin
        shared_port_pin_out <= latch_level;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Count has no write decode, so it is read only
  always_comb begin
    case (reg_addr)
      ADDR_PORT5_DIRECTION: rdata_next = port5_direction_reg;
      ADDR_PORT5_LATCH: rdata_next = port5_latch_reg;
      ADDR_TIMER_MODE_CONTROL: rdata_next = timer_mode_control_reg;
      ADDR_COMPARE_VALUE: rdata_next = compare_value_reg;
      ADDR_COUNT_VALUE: rdata_next = count_value_reg;
      default: rdata_next = READ_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

endmodule : timer_event_counter

//--- hdl/timer_event_pkg.sv
/*
  Constants for the 8-bit timer/event counter: register addresses, field
  positions, reset values and the count-clock selection codes.
  Assumes an 8-bit memory-mapped register port with a 16-bit address.
*/
package timer_event_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PORT5_DIRECTION = 16'hff25;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_MODE_CONTROL = 16'hff53;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_VALUE = 16'hff54;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_VALUE = 16'hff55;
  localparam logic [ADDR_W-1:0] ADDR_PORT5_LATCH = 16'hff05;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] PORT5_DIRECTION_RESET = 8'hff;
  localparam logic [DATA_W-1:0] TIMER_MODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COMPARE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PORT5_LATCH_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  // Bits 7..4 of the direction register read as one
  localparam logic [DATA_W-1:0] PORT5_DIR_FIXED = 8'hf0;
  localparam int PORT5_PINS = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int COUNT_ENABLE_BIT = 7;
  localparam int CLOCK_SELECT_HI = 2;
  localparam int CLOCK_SELECT_LO = 1;
  localparam int OUTPUT_ENABLE_BIT = 0;
  localparam int SHARED_PIN_DIR_BIT = 0;
  localparam logic [DATA_W-1:0] TIMER_MODE_MASK = 8'h87;

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_SYSTEM = 2'h0,
    CLK_DIV32 = 2'h1,
    CLK_EDGE_RISE = 2'h2,
    CLK_EDGE_FALL = 2'h3
  } count_clock_e;

  localparam int PRESCALE_DIV = 32;
  localparam int PRESCALE_W = 5;

endpackage : timer_event_pkg

//--- test/event_source.sv
/*
  Pulse source on the shared pin.
  Assumes the bench resolves the pin against the timer's drive.
*/
`timescale 1ns/10ps
module event_source (
  input wire logic clk, // Clock
  output logic level // Driven level
);
  initial level = 1'b0;
  // Levels held long enough for the input synchroniser
  task automatic drive(input logic v, input int hold);
    @(negedge clk);
    level = v;
    repeat (hold) @(negedge clk);
  endtask : drive
endmodule : event_source

//--- test/tb.sv
/*
  Bench for the timer: reset values, interval, prescaled, event and square runs.
  Assumes DIV is shortened to 4.
*/
`timescale 1ns/10ps
module tb
  import timer_event_pkg::*;
;
  localparam int DIV_TB = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic pin_out, pin_oe, match_irq, src_level;
  int n_errors = 0;
  int checked = 0;
  int n_irq = 0;
  int n;
  wire pin = pin_oe ? pin_out : src_level;
  timer_event_counter #(.DIV(DIV_TB)) dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .shared_port_pin_in(pin), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe(pin_oe), .match_irq(match_irq));
  event_source src (.clk(clk), .level(src_level));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (match_irq === 1'b1) n_irq++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic irq_gap(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (match_irq !== 1'b1 && k < 3000);
  endtask : irq_gap
  // Stop, select clock, load compare, then enable, each in its own write
  task automatic start(input logic [DATA_W-1:0] mode, input logic [DATA_W-1:0] cmp);
    wr(ADDR_TIMER_MODE_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE_CONTROL, mode);
    wr(ADDR_COMPARE_VALUE, cmp);
    wr(ADDR_TIMER_MODE_CONTROL, mode | 8'h80);
  endtask : start
  task automatic period(input logic [DATA_W-1:0] mode, input logic [DATA_W-1:0] cmp,
                        input int exp);
    int k;
    start(mode, cmp);
    irq_gap(k);
    irq_gap(k);
    check(16'(k), 16'(exp));
  endtask : period
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    rd(ADDR_PORT5_DIRECTION, PORT5_DIRECTION_RESET);
    rd(ADDR_TIMER_MODE_CONTROL, TIMER_MODE_RESET);
    rd(ADDR_COUNT_VALUE, COUNT_RESET);
    rd(16'h0000, READ_ZERO);
    $display("test reset done");
    period(8'h00, 8'h00, 1);
    period(8'h00, 8'h03, 4);
    period(8'h00, 8'hff, 256);
    period(8'h02, 8'h01, 2 * DIV_TB);
    $display("test interval done");
    wr(ADDR_PORT5_DIRECTION, PORT5_DIRECTION_RESET);
    for (int s = 2; s < 4; s++) begin
      start(8'(s << 1), 8'h05);
      src.drive(1'b1, 6);
      rd(ADDR_COUNT_VALUE, 8'(s == 2));
      src.drive(1'b0, 6);
      rd(ADDR_COUNT_VALUE, COUNT_ONE);
    end
    start(8'h04, 8'h00);
    n = n_irq;
    repeat (3) begin
      src.drive(1'b1, 5);
      src.drive(1'b0, 5);
    end
    check(16'(n_irq - n), 16'h0003);
    start(8'h05, 8'h00);
    src.drive(1'b1, 5);
    src.drive(1'b0, 5);
    check(16'(pin_out), 16'h0000);
    $display("test event done");
    wr(ADDR_PORT5_LATCH, 8'h00);
    wr(ADDR_PORT5_DIRECTION, 8'hfe);
    start(8'h01, 8'h04);
    check(16'(pin_out), 16'h0000);
    check(16'(pin_oe), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      irq_gap(n);
      @(negedge clk);
      check(16'(pin_out), 16'(i % 2 == 0));
    end
    wr(ADDR_TIMER_MODE_CONTROL, 8'h01);
    repeat (2) @(negedge clk);
    check(16'(pin_out), 16'h0000);
    rd(ADDR_COUNT_VALUE, COUNT_RESET);
    $display("test square done");
    print_verdict();
  end
endmodule : tb

//--- test/timer_event_checker.sv
/*
  Port assertions for the timer, bound to each instance.
  Assumes registers change only through reg_wr.
*/
`timescale 1ns/10ps
module timer_event_checker
  import timer_event_pkg::*;
#(
  parameter int DIV = PRESCALE_DIV
) (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic [ADDR_W-1:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [DATA_W-1:0] reg_wdata, // Data in
  input wire logic [DATA_W-1:0] reg_rdata, // Data out
  input wire logic shared_port_pin_in, // Pin in
  input wire logic shared_port_pin_out, // Pin out
  input wire logic shared_port_pin_oe, // Pin drive
  input wire logic match_irq // Match
);
  // ------
  // Shadows
  // ------
  logic en_reg;
  logic latch_reg;
  logic [DATA_W-1:0] cmp_reg;
  wire stop_wr = reg_wr && reg_addr == ADDR_TIMER_MODE_CONTROL && !reg_wdata[7];
  always_ff @(posedge clk) begin
    if (reset) begin
      en_reg <= 1'b0;
      latch_reg <= 1'b0;
      cmp_reg <= COMPARE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_TIMER_MODE_CONTROL) en_reg <= reg_wdata[7];
      if (reg_addr == ADDR_PORT5_LATCH) latch_reg <= reg_wdata[0];
      if (reg_addr == ADDR_COMPARE_VALUE) cmp_reg <= reg_wdata;
    end
  end
  a_reset_quiet: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> !match_irq && !shared_port_pin_oe && reg_rdata == READ_ZERO)
    else $error("outputs busy after reset");
  a_dir_to_oe: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == ADDR_PORT5_DIRECTION |-> ##2 shared_port_pin_oe == !$past(reg_wdata[0], 2))
    else $error("pin drive wrong");
  a_dir_read: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == ADDR_PORT5_DIRECTION |=> reg_rdata[7:4] == 4'hf)
    else $error("fixed direction bits wrong");
  a_irq_single: assert property (@(posedge clk) disable iff (reset)
    match_irq && cmp_reg != COMPARE_RESET |=> !match_irq)
    else $error("match pulse too long");
  a_stop_quiet: assert property (@(posedge clk) disable iff (reset)
    stop_wr |-> ##2 !match_irq)
    else $error("match while stopped");
  a_stop_low: assert property (@(posedge clk) disable iff (reset)
    stop_wr && !latch_reg |-> ##3 !shared_port_pin_out)
    else $error("output high after stop");
  a_count_held: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == ADDR_COUNT_VALUE && !en_reg && !$past(en_reg) |=> reg_rdata == COUNT_RESET)
    else $error("count not held at zero");
  a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : timer_event_checker
bind timer_event_counter timer_event_checker #(.DIV(DIV)) chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .shared_port_pin_in(shared_port_pin_in),
  .shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe(shared_port_pin_oe),
  .match_irq(match_irq));
